// file: hw/sbd_consts.svh
`ifndef SBD_CONSTS_SVH
`define SBD_CONSTS_SVH
// region bases and sizes (bytes)
`define SBD_FLASH_BASE  32'h0000_0000
`define SBD_FLASH_SIZE  32'h0002_0000
`define SBD_RAM_BASE    32'h2000_0000
`define SBD_RAM_SIZE    32'h0000_4000
`define SBD_DRAM_BASE   32'h2020_0000
`define SBD_DRAM_SIZE   32'h0000_0070
`define SBD_PER16_BASE  32'h4000_0000
`define SBD_PER16_SIZE  32'h0000_1000
`define SBD_PER32_BASE  32'h4000_1000
`define SBD_PER32_SIZE  32'h0000_2000
`define SBD_ROMT_BASE   32'hF000_0000
`define SBD_ROMT_SIZE   32'h0000_1000
`define SBD_TRACE_BASE  32'hF020_0000
`define SBD_TRACE_SIZE  32'h0002_4000
// beat counts and flash wait reset setting
`define SBD_ONE_BEAT    3'h1
`define SBD_TWO_BEATS   3'h2
`define SBD_FOUR_BEATS  3'h4
`define SBD_WAIT_RESET  2'h0
`endif

// file: hw/sbd_pkg.sv
package sbd_pkg;
  typedef enum logic [1:0] {
    SBD_SZ_BYTE,
    SBD_SZ_HALF,
    SBD_SZ_WORD
  } sbd_size_e;
  typedef enum logic [1:0] {
    SBD_DW_8,
    SBD_DW_16,
    SBD_DW_32
  } sbd_width_e;
  typedef enum logic [3:0] {
    SBD_TGT_NONE,
    SBD_TGT_FLASH,
    SBD_TGT_RAM,
    SBD_TGT_DRAM,
    SBD_TGT_PER16,
    SBD_TGT_PER32,
    SBD_TGT_ROMT,
    SBD_TGT_TRACE
  } sbd_target_e;
  typedef struct packed {
    logic [31:0] addr;
    sbd_size_e   size;
    logic        write;
    logic [31:0] wdata;
  } sbd_req_s;
  typedef struct packed {
    logic [31:0] addr;
    sbd_size_e   size;
    logic        write;
    logic [31:0] wdata;
    sbd_target_e target;
  } sbd_beat_s;
endpackage

// file: hw/sbd_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "sbd_consts.svh"
module sbd_decode
  import sbd_pkg::*;
(
  // request
  input  wire logic [31:0] addr,
  input  wire sbd_size_e   size,
  // decode result
  output sbd_target_e      target,
  output sbd_width_e       width,
  output logic [2:0]       beats
);
  // full 32-bit space, fetch and data alike
  always_comb begin
    target = SBD_TGT_NONE;
    width  = SBD_DW_32;
    if (addr - `SBD_FLASH_BASE < `SBD_FLASH_SIZE) begin
      target = SBD_TGT_FLASH;
    end else if (addr - `SBD_RAM_BASE < `SBD_RAM_SIZE) begin
      target = SBD_TGT_RAM;
    end else if (addr - `SBD_DRAM_BASE < `SBD_DRAM_SIZE) begin
      target = SBD_TGT_DRAM;
    end else if (addr - `SBD_PER16_BASE < `SBD_PER16_SIZE) begin
      target = SBD_TGT_PER16;
      width  = SBD_DW_16;
    end else if (addr - `SBD_PER32_BASE < `SBD_PER32_SIZE) begin
      target = SBD_TGT_PER32;
    end else if (addr - `SBD_ROMT_BASE < `SBD_ROMT_SIZE) begin
      target = SBD_TGT_ROMT;
    end else if (addr - `SBD_TRACE_BASE < `SBD_TRACE_SIZE) begin
      target = SBD_TGT_TRACE;
    end
  end
  // beats by device width and access size
  always_comb begin
    beats = `SBD_ONE_BEAT;
    if (width == SBD_DW_8) begin
      if (size == SBD_SZ_HALF) begin
        beats = `SBD_TWO_BEATS;
      end else if (size == SBD_SZ_WORD) begin
        beats = `SBD_FOUR_BEATS;
      end
    end else if (width == SBD_DW_16 && size == SBD_SZ_WORD) begin
      beats = `SBD_TWO_BEATS;
    end
  end
endmodule
`default_nettype wire

// file: hw/sbd_fabric.sv
// Contract
// - one bus cycle equals one clock period
// - beats follow target width and access size
// - 4K region at 0x40000000 is 16-bit
// - 8K region after it is 32-bit
// - 128K flash at zero, 32-bit
// - vector table sits at flash start
// - 16K work RAM at 0x20000000
// - 112-byte display RAM at 0x20200000
// - 4K ROM table at 0xF0000000
// - 144K trace buffer at 0xF0200000
// - flash reads add configured wait cycles
// - full 4G space for fetch and data
`timescale 1ns/100ps
`default_nettype none
`include "sbd_consts.svh"
module sbd_fabric
  import sbd_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // master request
  input  wire logic        req_valid,
  input  wire sbd_req_s    req,
  output logic             req_ready_ff,
  // master answer
  output logic             rsp_valid_ff,
  output logic [31:0]      rsp_rdata_ff,
  // flash wait setting
  input  wire logic [1:0]  flash_read_wait_select,
  // target side, one beat per clock
  output logic             beat_valid_ff,
  output sbd_beat_s        beat_ff,
  input  wire logic [31:0] beat_rdata
);
  typedef enum {SBD_IDLE, SBD_BEAT, SBD_WAIT} sbd_state_e;

  sbd_state_e  state_ff;
  sbd_state_e  nxt_state;
  sbd_target_e dec_target;
  sbd_width_e  dec_width;
  logic [2:0]  dec_beats;
  logic [2:0]  left_ff;
  logic [1:0]  wait_ff;
  logic [1:0]  wait_cfg_ff;
  logic [31:0] acc_ff;
  logic [4:0]  shift_ff;
  logic [4:0]  step;
  logic [31:0] lane_mask;
  logic [31:0] lane_data;
  logic        take;
  logic        flash_hold;
  logic        last_beat;
  logic        split_next;
  logic        wait_done;

  sbd_decode u_decode (
    .addr   (req.addr),
    .size   (req.size),
    .target (dec_target),
    .width  (dec_width),
    .beats  (dec_beats)
  );

  // a request is taken only while idle and ready
  assign take = req_valid && req_ready_ff && state_ff == SBD_IDLE;

  // flash reads with a nonzero wait setting park in the wait state
  assign flash_hold = beat_ff.target == SBD_TGT_FLASH && !beat_ff.write
                   && wait_cfg_ff != `SBD_WAIT_RESET;

  assign last_beat  = state_ff == SBD_BEAT && !flash_hold
                   && left_ff == `SBD_ONE_BEAT;
  assign split_next = state_ff == SBD_BEAT && !flash_hold
                   && left_ff != `SBD_ONE_BEAT;
  assign wait_done  = state_ff == SBD_WAIT && wait_ff == 2'h1;

  // step in bit lanes between beats of a split access
  assign step = (beat_ff.size == SBD_SZ_HALF) ? 5'h10 : 5'h08;

  // a split beat owns only the low lanes of the target data
  assign lane_mask = (beat_ff.size == SBD_SZ_HALF) ? 32'h0000_FFFF
                   : 32'h0000_00FF;

  always_comb begin
    lane_data = beat_rdata;
    if (beat_ff.target == SBD_TGT_NONE) begin
      lane_data = 32'h0000_0000;
    end else if (!(shift_ff == 5'h00 && left_ff == `SBD_ONE_BEAT)) begin
      lane_data = (beat_rdata & lane_mask) << shift_ff;
    end
  end

  // next state of the sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SBD_IDLE: begin
        if (take) begin
          nxt_state = SBD_BEAT;
        end
      end
      SBD_BEAT: begin
        if (flash_hold) begin
          nxt_state = SBD_WAIT;
        end else if (left_ff == `SBD_ONE_BEAT) begin
          nxt_state = SBD_IDLE;
        end
      end
      SBD_WAIT: begin
        if (wait_ff == 2'h1) begin
          nxt_state = SBD_IDLE;
        end
      end
      default: nxt_state = SBD_IDLE;
    endcase
  end

  // wait setting taken at access start so it holds for the access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_cfg_ff <= `SBD_WAIT_RESET;
    end else if (state_ff == SBD_IDLE) begin
      wait_cfg_ff <= flash_read_wait_select;
    end
  end

  // sequencer: every transition is one clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= SBD_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // master stays stalled from take until the final beat or wait
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_ready_ff <= 1'b1;
    end else if (take) begin
      req_ready_ff <= 1'b0;
    end else if (last_beat || wait_done) begin
      req_ready_ff <= 1'b1;
    end
  end

  // beat strobe stands for every beat of the access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      beat_valid_ff <= 1'b0;
    end else if (take) begin
      beat_valid_ff <= 1'b1;
    end else if (last_beat || (state_ff == SBD_BEAT && flash_hold)) begin
      beat_valid_ff <= 1'b0;
    end
  end

  // beat fields: loaded at take, stepped between split beats
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      beat_ff <= '0;
    end else if (take) begin
      beat_ff.addr   <= req.addr;
      beat_ff.write  <= req.write;
      beat_ff.wdata  <= req.wdata;
      beat_ff.target <= dec_target;
      // a split beat carries the device width
      beat_ff.size   <= (dec_beats == `SBD_ONE_BEAT) ? req.size
                      : ((dec_width == SBD_DW_16) ? SBD_SZ_HALF
                      : SBD_SZ_BYTE);
    end else if (split_next) begin
      beat_ff.addr  <= beat_ff.addr + {29'h0, step[4:3]};
      beat_ff.wdata <= beat_ff.wdata >> step;
    end
  end

  // beats left and lane position of the current beat
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_ff  <= 3'h0;
      shift_ff <= 5'h00;
    end else if (take) begin
      left_ff  <= dec_beats;
      shift_ff <= 5'h00;
    end else if (split_next) begin
      left_ff  <= left_ff - 3'h1;
      shift_ff <= shift_ff + step;
    end
  end

  // flash wait countdown
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_ff <= 2'h0;
    end else if (state_ff == SBD_BEAT && flash_hold) begin
      wait_ff <= wait_cfg_ff;
    end else if (state_ff == SBD_WAIT) begin
      wait_ff <= wait_ff - 2'h1;
    end
  end

  // read data assembly and single completion pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_ff       <= 32'h0000_0000;
      rsp_valid_ff <= 1'b0;
      rsp_rdata_ff <= 32'h0000_0000;
    end else begin
      rsp_valid_ff <= 1'b0;
      if (state_ff == SBD_IDLE) begin
        acc_ff <= 32'h0000_0000;
      end
      if (state_ff == SBD_BEAT) begin
        acc_ff <= acc_ff | lane_data;
      end
      if (last_beat) begin
        rsp_valid_ff <= 1'b1;
        rsp_rdata_ff <= beat_ff.write ? 32'h0000_0000
                      : (acc_ff | lane_data);
      end
      if (wait_done) begin
        rsp_valid_ff <= 1'b1;
        rsp_rdata_ff <= acc_ff;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/sbd_tgt_model.sv
`timescale 1ns/100ps
`default_nettype none
module sbd_tgt_model
  import sbd_pkg::*;
(
  // beat from fabric
  input  wire logic      beat_valid_ff,
  input  wire sbd_beat_s beat_ff,
  // read data
  output logic [31:0]    beat_rdata
);
  // data is the beat address; lines flip when no beat is up
  assign beat_rdata = beat_valid_ff ? beat_ff.addr : ~beat_ff.addr;
endmodule
`default_nettype wire

// file: bench/sbd_fabric_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module sbd_fabric_asserts
  import sbd_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // master side
  input wire logic        req_valid,
  input wire sbd_req_s    req,
  input wire logic        req_ready_ff,
  input wire logic        rsp_valid_ff,
  input wire logic [31:0] rsp_rdata_ff,
  input wire logic [1:0]  flash_read_wait_select,
  // target side
  input wire logic        beat_valid_ff,
  input wire sbd_beat_s   beat_ff,
  input wire logic [31:0] beat_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic tk;
  logic wrd;
  logic fl;
  assign tk  = req_valid && req_ready_ff;
  assign wrd = tk && req.size == SBD_SZ_WORD;
  assign fl  = tk && req.addr[31:17] == 15'h0;
  sequence s_one; beat_valid_ff ##1 rsp_valid_ff; endsequence
  sequence s_two; beat_valid_ff[*2] ##1 rsp_valid_ff; endsequence
  AST_RAM_ONE: assert property (wrd && req.addr[31:14] == 18'h08000
    |=> s_one) else $error("ram word not one beat");
  AST_PER32_ONE: assert property (wrd && (req.addr[31:12] == 20'h40001
    || req.addr[31:12] == 20'h40002) |=> s_one) else $error("per32 beats");
  AST_PER16_TWO: assert property (wrd && req.addr[31:12] == 20'h40000
    |=> s_two) else $error("per16 word not two beats");
  AST_FLASH_W3: assert property (fl && !req.write
    && flash_read_wait_select == 2'h3 |=> (!rsp_valid_ff)[*4] ##1
    rsp_valid_ff) else $error("flash wait 3 wrong");
  AST_VECTOR: assert property (fl |=> beat_ff.target == SBD_TGT_FLASH)
    else $error("flash start not decoded");
  AST_STALL: assert property (beat_valid_ff |-> !req_ready_ff
    && !rsp_valid_ff) else $error("ready during beats");
  AST_PULSE: assert property (rsp_valid_ff |=> !rsp_valid_ff)
    else $error("answer longer than one cycle");
  AST_SPLIT_ADDR: assert property (beat_valid_ff && $past(beat_valid_ff)
    && beat_ff.target == SBD_TGT_PER16 |-> beat_ff.addr ==
    $past(beat_ff.addr) + 32'h2) else $error("split address step");
  AST_RSV_ZERO: assert property (rsp_valid_ff
    && $past(beat_ff.target) == SBD_TGT_NONE |-> rsp_rdata_ff == 32'h0)
    else $error("reserved read not zero");
endmodule
bind sbd_fabric sbd_fabric_asserts sbd_fabric_asserts_inst (
  .clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
  .req_ready_ff(req_ready_ff), .rsp_valid_ff(rsp_valid_ff),
  .rsp_rdata_ff(rsp_rdata_ff),
  .flash_read_wait_select(flash_read_wait_select),
  .beat_valid_ff(beat_valid_ff), .beat_ff(beat_ff),
  .beat_rdata(beat_rdata));
`default_nettype wire

// file: bench/system_bus_decode_and_sizing_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  mismatches++; $display("Error %0t: %h vs %h", $time, a, b); end end
module system_bus_decode_and_sizing_tb_top
  import sbd_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rv = 1'b0;
  sbd_req_s    rq = '0;
  logic [1:0]  ws = 2'h0;
  logic        rdy, rsp, bv;
  logic [31:0] rd, br;
  sbd_beat_s   bt;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cyc = 0;
  always #5 clk = ~clk;
  sbd_fabric sbd_fabric_inst (.clk(clk), .rst(rst), .req_valid(rv),
    .req(rq), .req_ready_ff(rdy), .rsp_valid_ff(rsp), .rsp_rdata_ff(rd),
    .flash_read_wait_select(ws), .beat_valid_ff(bv), .beat_ff(bt),
    .beat_rdata(br));
  sbd_tgt_model sbd_tgt_model_inst (.beat_valid_ff(bv), .beat_ff(bt),
    .beat_rdata(br));
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one access; n is the cycle count from take to answer
  task automatic acc(input logic [31:0] a, input sbd_size_e s,
                     input logic w, output int n);
    @(negedge clk);
    rv = 1'b1;
    rq = '{a, s, w, ~a};
    @(negedge clk);
    rv = 1'b0;
    n = 0;
    while (rsp !== 1'b1 && n < 9) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic t_regions;
    logic [31:0] a [5] = '{32'h2000_3FFC, 32'h2020_006C, 32'h4000_2FFC,
                           32'hF000_0FFC, 32'hF022_3FFC};
    int n;
    foreach (a[i]) begin
      acc(a[i], SBD_SZ_WORD, 1'b0, n);
      `CHK(n, 1)
      `CHK(rd, a[i])
    end
  endtask
  task automatic t_split;
    int n;
    acc(32'h4000_0FFC, SBD_SZ_WORD, 1'b0, n);
    `CHK(n, 2)
    `CHK(rd, 32'h0FFE_0FFC)
    acc(32'h4000_0FFE, SBD_SZ_HALF, 1'b1, n);
    `CHK(n, 1)
    acc(32'h4000_0001, SBD_SZ_BYTE, 1'b0, n);
    `CHK(n, 1)
  endtask
  task automatic t_wait;
    int n;
    for (int w = 0; w < 4; w++) begin
      ws = 2'(w);
      acc(32'h0000_0000, SBD_SZ_WORD, 1'b0, n);
      `CHK(n, w + 1)
      `CHK(rd, 32'h0)
    end
    acc(32'h0001_FFFC, SBD_SZ_WORD, 1'b1, n);
    `CHK(n, 1)
  endtask
  task automatic t_rsv;
    int n;
    acc(32'h2000_4000, SBD_SZ_WORD, 1'b0, n);
    `CHK(n, 1)
    `CHK(rd, 32'h0)
    acc(32'hF022_4000, SBD_SZ_HALF, 1'b0, n);
    `CHK(n, 1)
    `CHK(rd, 32'h0)
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_regions();
    t_split();
    t_wait();
    t_rsv();
    end_sim();
  end
endmodule
`default_nettype wire
